/* File: logic/secl_loader.sv */
/*
  Power-up configuration loader: reads a seven byte image from a serial
  eeprom over the two-wire bus, then on success hands the bus back for slave use.
  Assumes a slave engine elsewhere is enabled by slave_mode, and that the
  eeprom and any chained siblings keep off the bus until this load ends.
*/
// Operation
// - wait idle until load request low
// - become master, read eeprom at A0
// - on success drive done low, slave
// - release bus, answer as slave
// - load mapped bits only, others default
// - map eeprom byte bits to registers
// - device data is bytes 03 to 06
// - first three bytes are base header
// - boost fields and bypass set gain
`timescale 1ns/1ps
module secl_loader
  import secl_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_role_strap,
  input wire logic load_req_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic load_done_n,
  output logic slave_mode,
  output logic load_busy,
  output logic load_failed,
  output logic [7:0] cfg_reg03,
  output logic [7:0] cfg_reg04,
  output logic [7:0] cfg_reg06,
  output logic [7:0] cfg_reg08,
  output logic [7:0] cfg_reg0d,
  output logic [7:0] cfg_reg15,
  output logic [7:0] cfg_reg16,
  output logic [7:0] cfg_reg17,
  output logic [2:0] ctle_boost_stage_one,
  output logic [2:0] ctle_boost_stage_two,
  output logic ctle_bypass_select,
  output logic hdr_crc_enable,
  output logic hdr_addr_map_enable,
  output logic hdr_large_eeprom,
  output logic hdr_common_channel,
  output logic [3:0] hdr_device_count,
  output logic [7:0] hdr_max_burst
);

  secl_load_state_type state_r;
  logic strap_taken_r;
  logic wait_r;
  logic fail_r;
  logic done_n_r;
  logic [2:0] idx_r;
  logic [7:0] img_r [IMG_BYTES];
  logic [7:0] r03_r, r04_r, r06_r, r08_r, r0d_r, r15_r, r16_r, r17_r;
  logic [7:0] hdr0_r;
  logic [7:0] hdr2_r;
  logic issuing;
  logic cmd_valid;
  secl_cmd_type cmd;
  logic [7:0] tx_byte;
  logic rx_nack;
  logic eng_ready, eng_done, eng_ack_err;
  logic [7:0] eng_rx;
  logic eng_scl_oe, eng_sda_oe;
  logic commit;

  secl_bit_engine #(
    .QTR(QTR)
  ) u_eng (
    .sys_clk(sys_clk),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .tx_byte(tx_byte),
    .rx_nack(rx_nack),
    .cmd_ready(eng_ready),
    .done(eng_done),
    .ack_err(eng_ack_err),
    .rx_byte(eng_rx),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_oe(eng_scl_oe),
    .sda_oe(eng_sda_oe)
  );

  // open drain: the pin is only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = eng_scl_oe && load_busy;
  assign sda_oe = eng_sda_oe && load_busy;
  assign load_busy = (state_r >= L_START) && (state_r <= L_STOP);
  assign load_failed = (state_r == L_FAIL);
  assign load_done_n = done_n_r;
  assign slave_mode = (state_r == L_DONE) || (state_r == L_SLAVE);
  assign issuing = load_busy && (state_r != L_STOP || eng_ready);
  assign cmd_valid = issuing && eng_ready && !wait_r;
  assign commit = (state_r == L_STOP) && eng_done && !fail_r;

  always_comb begin
    cmd = ENG_START;
    tx_byte = 8'hFF;
    rx_nack = 1'b0;
    case (state_r)
      L_DEVW: begin
        cmd = ENG_WRITE;
        tx_byte = EEPROM_ADDR_WR;
      end
      L_OFFS: begin
        cmd = ENG_WRITE;
        tx_byte = EEPROM_FIRST_OFFSET;
      end
      L_DEVR: begin
        cmd = ENG_WRITE;
        tx_byte = EEPROM_ADDR_RD;
      end
      L_READ: begin
        cmd = ENG_READ;
        rx_nack = (idx_r == IMG_DATA_LAST);
      end
      L_STOP: cmd = ENG_STOP;
      default: cmd = ENG_START;
    endcase
  end

  // strap read in every idle cycle from the second cycle after reset release, never under the reset itself
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_taken_r <= 1'b0;
    end else begin
      strap_taken_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b0;
    end else if (cmd_valid) begin
      wait_r <= 1'b1;
    end else if (eng_done) begin
      wait_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= L_IDLE;
      fail_r <= 1'b0;
      idx_r <= IMG_HDR0;
    end else begin
      case (state_r)
        L_IDLE: begin
          if (strap_taken_r && !bus_role_strap) begin
            state_r <= L_SLAVE;
          // request may be a sibling done
          end else if (strap_taken_r && !load_req_n) begin
            state_r <= L_START;
            fail_r <= 1'b0;
            idx_r <= IMG_HDR0;
          end
        end
        L_START: if (eng_done) state_r <= L_DEVW;
        L_DEVW, L_OFFS, L_DEVR: begin
          if (eng_done) begin
            if (eng_ack_err) begin
              fail_r <= 1'b1;
              state_r <= L_STOP;
            end else if (state_r == L_DEVW) begin
              state_r <= L_OFFS;
            end else if (state_r == L_OFFS) begin
              state_r <= L_RSTART;
            end else begin
              state_r <= L_READ;
            end
          end
        end
        L_RSTART: if (eng_done) state_r <= L_DEVR;
        L_READ: begin
          if (eng_done) begin
            if (idx_r == IMG_DATA_LAST) begin
              state_r <= L_STOP;
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end
        end
        L_STOP: if (eng_done) state_r <= fail_r ? L_FAIL : L_DONE;
        L_DONE, L_FAIL, L_SLAVE: state_r <= state_r;
        default: state_r <= L_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < IMG_BYTES; i++) begin
        img_r[i] <= 8'h00;
      end
    end else if (state_r == L_READ && eng_done) begin
      img_r[idx_r] <= eng_rx;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_n_r <= 1'b1;
    end else if (commit) begin
      done_n_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hdr0_r <= 8'h00;
      hdr2_r <= 8'h00;
    end else if (commit) begin
      hdr0_r <= img_r[IMG_HDR0];
      hdr2_r <= img_r[IMG_HDR2];
    end
  end

  assign hdr_crc_enable = hdr0_r[HDR_CRC_BIT];
  assign hdr_addr_map_enable = hdr0_r[HDR_MAP_BIT];
  assign hdr_large_eeprom = hdr0_r[HDR_LARGE_BIT];
  assign hdr_common_channel = hdr0_r[HDR_COMMON_BIT];
  assign hdr_device_count = hdr0_r[HDR_COUNT_MSB:0];
  assign hdr_max_burst = hdr2_r;

  // data bytes 03 to 06 applied
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r03_r <= REG03_RST;
      r04_r <= REG04_RST;
      r06_r <= REG06_RST;
      r08_r <= REG08_RST;
      r0d_r <= REG0D_RST;
      r15_r <= REG15_RST;
      r16_r <= REG16_RST;
      r17_r <= REG17_RST;
    end else if (commit) begin
      r03_r <= img_r[IMG_DATA_FIRST];
      r04_r[6:3] <= img_r[4][7:4];
      r04_r[0] <= img_r[4][3];
      r06_r[7:5] <= img_r[4][2:0];
      r06_r[4:2] <= img_r[5][7:5];
      r08_r[3:2] <= img_r[5][4:3];
      r0d_r[6:4] <= img_r[5][2:0];
      r15_r[6] <= img_r[IMG_DATA_LAST][7];
      r15_r[3:2] <= img_r[IMG_DATA_LAST][6:5];
      r16_r[6] <= img_r[IMG_DATA_LAST][4];
      r17_r[2:0] <= img_r[IMG_DATA_LAST][3:1];
    end
  end

  assign cfg_reg03 = r03_r;
  assign cfg_reg04 = r04_r;
  assign cfg_reg06 = r06_r;
  assign cfg_reg08 = r08_r;
  assign cfg_reg0d = r0d_r;
  assign cfg_reg15 = r15_r;
  assign cfg_reg16 = r16_r;
  assign cfg_reg17 = r17_r;
  assign ctle_boost_stage_one = r03_r[2:0];
  assign ctle_boost_stage_two = r03_r[5:3];
  assign ctle_bypass_select = r04_r[0];

endmodule : secl_loader

/* File: inc/secl_pkg.sv */
/*
  Shared constants and types for the EEPROM configuration loader.
  Assumes a 50 MHz system clock and an open-drain two-wire bus at 400 kHz.
*/
package secl_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_FREQ_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_FREQ_KHZ;
  // a quarter bit is a least time, so it rounds up
  localparam int QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // eeprom addressing
  localparam logic [7:0] EEPROM_ADDR_WR = 8'hA0;
  localparam logic [7:0] EEPROM_ADDR_RD = 8'hA1;
  localparam logic [7:0] EEPROM_FIRST_OFFSET = 8'h00;
  localparam logic [2:0] IMG_HDR0 = 3'h0;
  localparam logic [2:0] IMG_HDR2 = 3'h2;
  localparam logic [2:0] IMG_DATA_FIRST = 3'h3;
  localparam logic [2:0] IMG_DATA_LAST = 3'h6;
  localparam int IMG_BYTES = 7;

  // base header byte 0 field positions
  localparam int HDR_CRC_BIT = 7;
  localparam int HDR_MAP_BIT = 6;
  localparam int HDR_LARGE_BIT = 5;
  localparam int HDR_COMMON_BIT = 4;
  localparam int HDR_COUNT_MSB = 3;

  // slave register reset values (bits with no eeprom home stay here)
  localparam logic [7:0] REG03_RST = 8'h80;
  localparam logic [7:0] REG04_RST = 8'h10;
  localparam logic [7:0] REG06_RST = 8'hC0;
  localparam logic [7:0] REG08_RST = 8'h08;
  localparam logic [7:0] REG0D_RST = 8'h00;
  localparam logic [7:0] REG15_RST = 8'h00;
  localparam logic [7:0] REG16_RST = 8'h40;
  localparam logic [7:0] REG17_RST = 8'h04;

  typedef enum logic [1:0] {
    ENG_START = 2'b00,
    ENG_WRITE = 2'b01,
    ENG_READ = 2'b10,
    ENG_STOP = 2'b11
  } secl_cmd_type;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_START = 2'b01,
    E_BIT = 2'b10,
    E_STOP = 2'b11
  } secl_eng_state_type;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0000,
    L_START = 4'b0001,
    L_DEVW = 4'b0010,
    L_OFFS = 4'b0011,
    L_RSTART = 4'b0100,
    L_DEVR = 4'b0101,
    L_READ = 4'b0110,
    L_STOP = 4'b0111,
    L_DONE = 4'b1000,
    L_FAIL = 4'b1001,
    L_SLAVE = 4'b1010
  } secl_load_state_type;

endpackage : secl_pkg

/* File: logic/secl_bit_engine.sv */
/*
  Two-wire master bit engine: start, byte write, byte read, stop.
  Assumes pin inputs are synchronous to sys_clk and pins are open drain.
*/
`timescale 1ns/1ps
module secl_bit_engine
  import secl_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire secl_cmd_type cmd,
  input wire logic [7:0] tx_byte,
  input wire logic rx_nack,
  output logic cmd_ready,
  output logic done,
  output logic ack_err,
  output logic [7:0] rx_byte,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);

  localparam int CW = $clog2(QTR + 1);

  secl_eng_state_type state_r;
  logic [CW-1:0] qcnt_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic samp_r;
  logic done_r;
  logic ack_err_r;
  logic [7:0] rx_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic tick;
  logic hold;
  logic scl_lvl;
  logic sda_lvl;

  assign cmd_ready = (state_r == E_IDLE);
  assign done = done_r;
  assign ack_err = ack_err_r;
  assign rx_byte = rx_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign tick = (qcnt_r == CW'(QTR - 1));
  // a slave holding scl low stretches the high phase
  assign hold = (state_r != E_IDLE) && (phase_r == 2'd1) && !scl_in;

  always_comb begin
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    case (state_r)
      E_START: begin
        scl_lvl = (phase_r == 2'd1) || (phase_r == 2'd2);
        sda_lvl = (phase_r == 2'd0) || (phase_r == 2'd1);
      end
      E_BIT: begin
        scl_lvl = (phase_r == 2'd1) || (phase_r == 2'd2);
        sda_lvl = sh_r[8];
      end
      E_STOP: begin
        scl_lvl = (phase_r != 2'd0);
        sda_lvl = phase_r[1];
      end
      default: begin
        scl_lvl = 1'b1;
        sda_lvl = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qcnt_r <= '0;
    end else if (state_r == E_IDLE || tick) begin
      qcnt_r <= '0;
    end else if (!hold) begin
      qcnt_r <= qcnt_r + CW'(1);
    end
  end

  // pins hold their level between commands so the master keeps scl low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (state_r != E_IDLE) begin
      scl_oe_r <= ~scl_lvl;
      sda_oe_r <= ~sda_lvl;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= E_IDLE;
      phase_r <= 2'd0;
      bit_r <= 4'h0;
      sh_r <= 9'h1FF;
      samp_r <= 1'b1;
      done_r <= 1'b0;
      ack_err_r <= 1'b0;
      rx_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        E_IDLE: begin
          if (cmd_valid) begin
            phase_r <= 2'd0;
            bit_r <= 4'h0;
            case (cmd)
              ENG_START: state_r <= E_START;
              ENG_STOP: state_r <= E_STOP;
              ENG_WRITE: begin
                sh_r <= {tx_byte, 1'b1};
                state_r <= E_BIT;
              end
              default: begin
                sh_r <= {8'hFF, rx_nack};
                state_r <= E_BIT;
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            phase_r <= phase_r + 2'd1;
            if (phase_r == 2'd2) begin
              samp_r <= sda_in;
            end
            if (phase_r == 2'd3) begin
              if (state_r == E_BIT) begin
                sh_r <= {sh_r[7:0], samp_r};
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8) begin
                  state_r <= E_IDLE;
                  done_r <= 1'b1;
                  rx_r <= sh_r[7:0];
                  ack_err_r <= samp_r;
                end
              end else begin
                state_r <= E_IDLE;
                done_r <= 1'b1;
                ack_err_r <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

endmodule : secl_bit_engine

/* File: sim/secl_loader_sva.sv */
/*
  Port-level properties of the eeprom configuration loader.
  Assumes one clock domain and the async active-high reset.
*/
`timescale 1ns/1ps
module secl_loader_sva
  import secl_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_role_strap,
  input wire logic load_req_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic load_done_n,
  input wire logic slave_mode,
  input wire logic load_busy,
  input wire logic load_failed,
  input wire logic [7:0] cfg_reg03,
  input wire logic [7:0] cfg_reg04,
  input wire logic [7:0] cfg_reg06,
  input wire logic [7:0] cfg_reg08,
  input wire logic [7:0] cfg_reg0d,
  input wire logic [7:0] cfg_reg15,
  input wire logic [7:0] cfg_reg16,
  input wire logic [7:0] cfg_reg17,
  input wire logic [2:0] ctle_boost_stage_one,
  input wire logic [2:0] ctle_boost_stage_two,
  input wire logic ctle_bypass_select
);
  // start condition: phase 0 and phase 1, QTR cycles each, then the oe register
  localparam int START_LIM = 2 * QTR + 8;
  logic [63:0] cfg_all;
  assign cfg_all = {cfg_reg03, cfg_reg04, cfg_reg06, cfg_reg08,
    cfg_reg0d, cfg_reg15, cfg_reg16, cfg_reg17};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_START_CAUSE: assert property (
    $rose(load_busy) |-> !$past(load_req_n) && $past(bus_role_strap))
    else $error("load began without a request");
  AST_IDLE_QUIET: assert property (
    $fell(load_busy) |-> !$past(scl_oe) && !$past(sda_oe) && !scl_oe && !sda_oe)
    else $error("bus still held when the load ended");
  AST_START_BUS: assert property (
    $rose(load_busy) |-> ##[1:START_LIM] ($rose(sda_oe) && !scl_oe))
    else $error("no start condition after load began");
  AST_DONE_SLAVE: assert property (
    !load_done_n |-> slave_mode && !load_busy)
    else $error("done without slave role");
  AST_DONE_AFTER_LOAD: assert property (
    $fell(load_done_n) |-> $past(load_busy))
    else $error("done without a load");
  AST_DONE_HOLD: assert property (
    !load_done_n |=> !load_done_n)
    else $error("done output dropped");
  AST_SLAVE_RELEASE: assert property (
    slave_mode |-> !load_busy && !scl_oe && !sda_oe)
    else $error("slave still drives the bus");
  AST_CFG_COMMIT: assert property (
    !$stable(cfg_all) |-> ##[0:2] !load_done_n)
    else $error("settings changed without a good load");
  AST_GAIN_FIELDS: assert property (
    {ctle_boost_stage_two, ctle_boost_stage_one, ctle_bypass_select}
      == {cfg_reg03[5:0], cfg_reg04[0]})
    else $error("gain fields differ from settings");
  AST_FAIL_NO_DONE: assert property (
    load_failed |-> load_done_n && !load_busy)
    else $error("done after a failed load");
  cover property ($fell(load_done_n));
  cover property ($rose(load_failed));
  cover property ($rose(slave_mode) && load_done_n);
endmodule : secl_loader_sva

bind secl_loader secl_loader_sva #(.QTR(QTR)) secl_loader_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .bus_role_strap(bus_role_strap), .load_req_n(load_req_n),
  .scl_oe(scl_oe), .sda_oe(sda_oe), .load_done_n(load_done_n), .slave_mode(slave_mode),
  .load_busy(load_busy), .load_failed(load_failed), .cfg_reg03(cfg_reg03),
  .cfg_reg04(cfg_reg04), .cfg_reg06(cfg_reg06), .cfg_reg08(cfg_reg08),
  .cfg_reg0d(cfg_reg0d), .cfg_reg15(cfg_reg15), .cfg_reg16(cfg_reg16),
  .cfg_reg17(cfg_reg17), .ctle_boost_stage_one(ctle_boost_stage_one),
  .ctle_boost_stage_two(ctle_boost_stage_two), .ctle_bypass_select(ctle_bypass_select)
);

/* File: sim/secl_eeprom_model.sv */
/*
  Behavioural two-wire serial eeprom holding a seven byte image.
  Assumes the bench resolves open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module secl_eeprom_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [55:0] image,
  input wire logic refuse,
  input wire logic [7:0] stretch_ns,
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] sh = 8'h00;
  logic [2:0] ptr = 3'h0;
  int bitn = -2;
  int ph = 0;
  initial sda_pull = 1'b0;
  initial scl_pull = 1'b0;
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = -1;
    ph = 0;
  end
  // stop releases the data line
  always @(posedge sda) if (scl === 1'b1) begin
    bitn = -2;
    sda_pull = 1'b0;
  end
  always @(posedge scl) begin
    if (bitn >= 0 && bitn < 8)
      sh = {sh[6:0], sda};
    // master nack ends the read, so the stop is not blocked
    if (bitn == 8 && ph == 2 && sda)
      ph = 3;
  end
  always @(negedge scl) if (bitn > -2) begin
    bitn = (bitn == 8) ? 0 : bitn + 1;
    sda_pull = 1'b0;
    if (bitn == 8 && ph == 2)
      ptr = ptr + 3'h1;
    else if (bitn == 8 && ph == 1) begin
      ptr = sh[2:0];
      sda_pull = 1'b1;
    end
    else if (bitn == 8 && ph == 0 && sh[7:1] == 7'h50 && !refuse) begin
      sda_pull = 1'b1;
      ph = sh[0] ? 2 : 1;
    end
    if (bitn < 8 && ph == 2)
      sda_pull = ~image[55 - 8 * ptr - bitn];
  end
  // slow answer: hold the clock low a while
  always @(negedge scl) if (stretch_ns != 8'h00 && bitn > -2) begin
    scl_pull = 1'b1;
    #(stretch_ns);
    scl_pull = 1'b0;
  end
endmodule : secl_eeprom_model

/* File: sim/testbench.sv */
/*
  Self-checking bench for the eeprom configuration loader.
  Assumes pulled-up open-drain wires and one eeprom model.
*/
`timescale 1ns/1ps
module testbench;
  import secl_pkg::*;
  localparam logic [55:0] DEF = 56'h00000080261018;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bus_role_strap = 1'b1;
  logic load_req_n = 1'b1;
  logic refuse = 1'b0;
  logic [7:0] stretch = 8'h00;
  logic [55:0] image = DEF;
  logic scl_in, sda_in, scl_out, sda_out, scl_oe, sda_oe, m_sda, m_scl;
  logic load_done_n, slave_mode, load_busy, load_failed;
  logic [7:0] cfg_reg03, cfg_reg04, cfg_reg06, cfg_reg08;
  logic [7:0] cfg_reg0d, cfg_reg15, cfg_reg16, cfg_reg17, hdr_max_burst;
  logic [2:0] ctle_boost_stage_one, ctle_boost_stage_two;
  logic ctle_bypass_select, hdr_crc_enable, hdr_addr_map_enable;
  logic hdr_large_eeprom, hdr_common_channel;
  logic [3:0] hdr_device_count;
  logic [86:0] got;
  logic [91:0] notes[$];
  logic [91:0] note;
  int n_fail = 0;
  int checks = 0;
  logic [31:0] ctle [16] = '{32'h802E1018, 32'h982E1018, 32'h81261018,
    32'h91261018, 32'h8A261018, 32'h92261018, 32'h9A261018, 32'h93261018,
    32'h9B261018, 32'h9C261018, 32'h9D261018, 32'hA5261018, 32'hAD261018,
    32'hAE261018, 32'hB6261018, 32'hBF261018};
  assign scl_in = (scl_oe ? scl_out : 1'b1) & ~m_scl;
  assign sda_in = (sda_oe ? sda_out : 1'b1) & ~m_sda;
  assign got = {cfg_reg03, cfg_reg04, cfg_reg06, cfg_reg08, cfg_reg0d,
    cfg_reg15, cfg_reg16, cfg_reg17, ctle_boost_stage_one, ctle_boost_stage_two,
    ctle_bypass_select, hdr_crc_enable, hdr_addr_map_enable, hdr_large_eeprom,
    hdr_common_channel, hdr_device_count, hdr_max_burst};
  secl_loader #(.QTR(2)) secl_loader_inst (.sys_clk(sys_clk), .rst(rst),
    .bus_role_strap(bus_role_strap), .load_req_n(load_req_n), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .load_done_n(load_done_n), .slave_mode(slave_mode), .load_busy(load_busy),
    .load_failed(load_failed), .cfg_reg03(cfg_reg03), .cfg_reg04(cfg_reg04),
    .cfg_reg06(cfg_reg06), .cfg_reg08(cfg_reg08), .cfg_reg0d(cfg_reg0d),
    .cfg_reg15(cfg_reg15), .cfg_reg16(cfg_reg16), .cfg_reg17(cfg_reg17),
    .ctle_boost_stage_one(ctle_boost_stage_one), .ctle_boost_stage_two(ctle_boost_stage_two),
    .ctle_bypass_select(ctle_bypass_select), .hdr_crc_enable(hdr_crc_enable),
    .hdr_addr_map_enable(hdr_addr_map_enable), .hdr_large_eeprom(hdr_large_eeprom),
    .hdr_common_channel(hdr_common_channel), .hdr_device_count(hdr_device_count),
    .hdr_max_burst(hdr_max_burst));
  secl_eeprom_model secl_eeprom_model_inst (.scl(scl_in), .sda(sda_in),
    .image(image), .refuse(refuse), .stretch_ns(stretch), .sda_pull(m_sda),
    .scl_pull(m_scl));
  always #10 sys_clk = ~sys_clk;
  function automatic logic [86:0] exp_img(input logic [55:0] e);
    logic [7:0] b [7];
    for (int i = 0; i < 7; i++)
      b[i] = e[55 - 8 * i -: 8];
    return {b[3], 1'h0, b[4][7:4], 2'h0, b[4][3], b[4][2:0], b[5][7:5],
      2'h0, 4'h0, b[5][4:3], 2'h0, 1'h0, b[5][2:0], 4'h0, 1'h0, b[6][7], 2'h0,
      b[6][6:5], 2'h0, 1'h0, b[6][4], 6'h00, 5'h00, b[6][3:1], b[3][2:0],
      b[3][5:3], b[4][3], b[0], b[2]};
  endfunction : exp_img
  task automatic chk_img(input logic [86:0] e, input logic [86:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_img
  task automatic chk_st(input logic [4:0] e, input logic [4:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_st
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  // one load per reset: note the outcome, then request it
  task automatic run(input logic s, input logic [55:0] im, input logic rf,
    input logic [55:0] ei, input logic [4:0] est);
    int n;
    @(posedge sys_clk);
    #1 rst = 1'b1;
    load_req_n = 1'b1;
    bus_role_strap = s;
    image = im;
    refuse = rf;
    // odd stretch never lands on a clock edge
    stretch = $urandom_range(1) ? 8'h00 : 8'($urandom_range(120, 10) * 2 + 1);
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    notes.push_back({exp_img(ei), est});
    repeat (40) @(posedge sys_clk);
    #1 chk_st(5'h10, {load_done_n, load_busy, load_failed, scl_oe, sda_oe});
    load_req_n = 1'b0;
    n = 0;
    while (s && load_done_n && !load_failed && n < 8000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 8000) begin
      n_fail++;
      return;
    end
    repeat (4) @(posedge sys_clk);
    chk_st(5'(notes.size()), 5'h00);
  endtask : run
  // results show when the role turns to slave or the load fails
  always @(posedge slave_mode or posedge load_failed) begin
    @(negedge sys_clk);
    note = notes.size() ? notes.pop_front() : '1;
    chk_img(note[91:5], got);
    chk_st(note[4:0], {load_done_n, load_busy, load_failed, scl_oe, sda_oe});
  end
  initial begin
    void'($urandom(32'h7FCE5601));
    for (int i = 0; i < 16; i++) begin
      image = {24'($urandom), ctle[i]};
      run(1'b1, image, 1'b0, image, 5'h00);
    end
    run(1'b1, {24'($urandom), ctle[5]}, 1'b1, DEF, 5'h14);
    run(1'b0, {24'($urandom), ctle[9]}, 1'b0, DEF, 5'h10);
    close_out();
  end
endmodule : testbench
